// ===== adc_seq_pkg.sv
package adc_seq_pkg;

	// ==========================================================
	// Register indices and byte addresses (byte address = 4 * index)
	localparam logic [15:0] IDX_RESULT0 = 16'hFFE0;
	localparam logic [15:0] IDX_RESULT1 = 16'hFFE2;
	localparam logic [15:0] IDX_RESULT2 = 16'hFFE4;
	localparam logic [15:0] IDX_RESULT3 = 16'hFFE6;
	localparam logic [15:0] IDX_CSR     = 16'hFFE8;
	localparam logic [15:0] IDX_TRIG    = 16'hFFEA;
	localparam int          ADDR_W      = 18;
	localparam logic [17:0] ADDR_RESULT0 = {IDX_RESULT0, 2'h0};
	localparam logic [17:0] ADDR_RESULT1 = {IDX_RESULT1, 2'h0};
	localparam logic [17:0] ADDR_RESULT2 = {IDX_RESULT2, 2'h0};
	localparam logic [17:0] ADDR_RESULT3 = {IDX_RESULT3, 2'h0};
	localparam logic [17:0] ADDR_CSR     = {IDX_CSR, 2'h0};
	localparam logic [17:0] ADDR_TRIG    = {IDX_TRIG, 2'h0};

	// ==========================================================
	// Field positions
	localparam int BIT_END_FLAG = 7;
	localparam int BIT_IE       = 6;
	localparam int BIT_RUN      = 5;
	localparam int BIT_SCAN     = 4;
	localparam int BIT_SPEED    = 3;
	localparam int BIT_GROUP    = 2;
	localparam int BIT_TRIG_EN  = 7;

	// ==========================================================
	// Reset values
	localparam logic [7:0] CSR_RESET      = 8'h00;
	localparam logic [7:0] RESULT_RESET   = 8'h00;
	localparam logic [7:0] TRIG_RESET     = 8'h7F;
	localparam logic [6:0] TRIG_RESERVED  = 7'h7F;

	// ==========================================================
	// Conversion timing in states (one state = one aclk cycle)
	localparam int         STATES_SLOW   = 242;
	localparam int         STATES_FAST   = 122;
	localparam int         SAR_BITS      = 8;
	localparam logic [7:0] STEP_SLOW     = 8'h18;
	localparam logic [7:0] STEP_FAST     = 8'h0C;
	localparam logic [7:0] SAMPLE_SLOW   = 8'(STATES_SLOW - SAR_BITS * 24);
	localparam logic [7:0] SAMPLE_FAST   = 8'(STATES_FAST - SAR_BITS * 12);

	// ==========================================================
	// Bus responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		ST_IDLE   = 3'b001,
		ST_SAMPLE = 3'b010,
		ST_STEP   = 3'b100
	} conv_state_t;

endpackage

// ===== adc_sequence_control.sv
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// How it works
// R1: interrupt enable gates the end request
// R2: run bit runs converter; single end clears
// R3: scan repeats until run bit cleared
// R4: mode bit: zero single, one scan
// R5: speed bit: 242 or 122 states
// R6: group bit plus index pick channels
// R7: trigger register resets to 7F
// R8: enabled falling trigger sets run bit
// R9: low trigger bits read one, ignore writes
// R10: eight approximation steps give 8-bit code
// R11: conversion starts when run bit becomes one
// R12: single end: store, flag, clear run, halt
// R13: request raised when flag and enable set
// R14: flag clears by read then write zero
// R15: scan starts at group first channel
// R16: next scan channel starts immediately
// R17: scan results go to channel's register
// R18: software stops converter before changing settings
// R19: one write may configure and start
// R20: scan sets flag after whole pass
// R21: four result registers, channel k or k+4
// R22: control and results reset to zero
// R23: restart always begins at first channel
// R24: state counter timing; synchronised trigger
module adc_sequence_control #(
	parameter int DATA_W = 8
) (
	// Clock and reset
	input  wire logic                      aclk,
	input  wire logic                      aresetn,
	// AXI4-Lite write address
	input  wire logic [adc_seq_pkg::ADDR_W-1:0] awaddr,
	input  wire logic                      awvalid,
	output logic                           awready,
	// AXI4-Lite write data
	input  wire logic [31:0]               wdata,
	input  wire logic [3:0]                wstrb,
	input  wire logic                      wvalid,
	output logic                           wready,
	// AXI4-Lite write response
	output logic [1:0]                     bresp,
	output logic                           bvalid,
	input  wire logic                      bready,
	// AXI4-Lite read address
	input  wire logic [adc_seq_pkg::ADDR_W-1:0] araddr,
	input  wire logic                      arvalid,
	output logic                           arready,
	// AXI4-Lite read data
	output logic [31:0]                    rdata,
	output logic [1:0]                     rresp,
	output logic                           rvalid,
	input  wire logic                      rready,
	// Power management and trigger pin
	input  wire logic                      standby,
	input  wire logic                      external_trigger_n,
	// Analog front end
	input  wire logic                      comparator_high,
	output logic [2:0]                     analog_channel,
	output logic [DATA_W-1:0]              dac_code,
	output logic                           sampling,
	// Interrupt request
	output logic                           conversion_end_request
);

	// ==========================================================
	// Declarations
	adc_seq_pkg::conv_state_t state_reg;
	logic              end_flag_reg;
	logic              end_interrupt_enable_reg;
	logic              run_bit_reg;
	logic              scan_mode_reg;
	logic              speed_select_reg;
	logic [2:0]        channel_sel_reg;
	logic              trigger_enable_reg;
	logic              flag_read_armed_reg;
	logic [DATA_W-1:0] result_reg [4];
	logic [DATA_W-1:0] sar_reg;
	logic [2:0]        bit_idx_reg;
	logic [7:0]        timer_reg;
	logic [2:0]        channel_reg;
	logic              trig_meta_reg;
	logic              trig_sync_reg;
	logic              trig_prev_reg;
	logic              trig_fall;
	logic              aw_full_reg;
	logic              w_full_reg;
	logic [adc_seq_pkg::ADDR_W-1:0] aw_addr_reg;
	logic [7:0]        w_byte_reg;
	logic              w_lane0_reg;
	logic              do_write;
	logic              wr_csr;
	logic              wr_trig;
	logic              wr_hit;
	logic              rd_take;
	logic [31:0]       rd_value;
	logic              rd_hit;
	logic              conv_done;
	logic              last_channel;
	logic [7:0]        step_len;
	logic [7:0]        sample_len;
	logic [7:0]        csr_value;
	logic              init;

	// Reset and standby entry both initialise the converter
	assign init = !aresetn || standby;

	// ==========================================================
	// AXI4-Lite slave
	// Address and data are held independently so either may arrive first
	assign awready  = !aw_full_reg && !bvalid;
	assign wready   = !w_full_reg && !bvalid;
	assign do_write = aw_full_reg && w_full_reg && !bvalid;
	assign wr_hit   = (aw_addr_reg == adc_seq_pkg::ADDR_CSR) ||
	                  (aw_addr_reg == adc_seq_pkg::ADDR_TRIG);
	assign wr_csr   = do_write && w_lane0_reg && (aw_addr_reg == adc_seq_pkg::ADDR_CSR);
	assign wr_trig  = do_write && w_lane0_reg && (aw_addr_reg == adc_seq_pkg::ADDR_TRIG);
	// Capture write address
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_reg <= 1'b0;
			aw_addr_reg <= '0;
		end else if (awvalid && awready) begin
			aw_full_reg <= 1'b1;
			aw_addr_reg <= awaddr;
		end else if (do_write) begin
			aw_full_reg <= 1'b0;
		end
	end
	// Capture write data; only byte lane 0 carries register bits
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_full_reg  <= 1'b0;
			w_byte_reg  <= 8'h00;
			w_lane0_reg <= 1'b0;
		end else if (wvalid && wready) begin
			w_full_reg  <= 1'b1;
			w_byte_reg  <= wdata[7:0];
			w_lane0_reg <= wstrb[0];
		end else if (do_write) begin
			w_full_reg <= 1'b0;
		end
	end
	// Write response; read-only and unmapped addresses answer SLVERR
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp  <= adc_seq_pkg::RESP_OKAY;
		end else if (do_write) begin
			bvalid <= 1'b1;
			bresp  <= wr_hit ? adc_seq_pkg::RESP_OKAY : adc_seq_pkg::RESP_SLVERR;
		end else if (bready) begin
			bvalid <= 1'b0;
		end
	end

	// Read path
	assign arready = !rvalid;
	assign rd_take = arvalid && arready;
	assign csr_value = {end_flag_reg, end_interrupt_enable_reg, run_bit_reg,
	                    scan_mode_reg, speed_select_reg, channel_sel_reg};
	// Register read multiplexer
	always_comb begin
		rd_value = 32'h0000_0000;
		rd_hit   = 1'b1;
		unique case (araddr)
			adc_seq_pkg::ADDR_RESULT0: rd_value[7:0] = result_reg[0]; // R21
			adc_seq_pkg::ADDR_RESULT1: rd_value[7:0] = result_reg[1];
			adc_seq_pkg::ADDR_RESULT2: rd_value[7:0] = result_reg[2];
			adc_seq_pkg::ADDR_RESULT3: rd_value[7:0] = result_reg[3];
			adc_seq_pkg::ADDR_CSR:     rd_value[7:0] = csr_value;
			adc_seq_pkg::ADDR_TRIG:    rd_value[7:0] = {trigger_enable_reg,
			                                            adc_seq_pkg::TRIG_RESERVED}; // R9
			default:                   rd_hit = 1'b0;
		endcase
	end
	// Read answer one cycle after the address is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'b0;
			rdata  <= 32'h0000_0000;
			rresp  <= adc_seq_pkg::RESP_OKAY;
		end else if (rd_take) begin
			rvalid <= 1'b1;
			rdata  <= rd_value;
			rresp  <= rd_hit ? adc_seq_pkg::RESP_OKAY : adc_seq_pkg::RESP_SLVERR;
		end else if (rready) begin
			rvalid <= 1'b0;
		end
	end

	// ==========================================================
	// External trigger synchroniser and falling-edge detector
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			trig_meta_reg <= 1'b1;
			trig_sync_reg <= 1'b1;
			trig_prev_reg <= 1'b1;
		end else begin
			trig_meta_reg <= external_trigger_n; // R24
			trig_sync_reg <= trig_meta_reg;
			trig_prev_reg <= trig_sync_reg;
		end
	end
	assign trig_fall = trig_prev_reg && !trig_sync_reg;

	// ==========================================================
	// Control/status and trigger registers
	// Settings written together with the run bit apply to that start
	always_ff @(posedge aclk) begin
		if (init) begin
			end_interrupt_enable_reg <= adc_seq_pkg::CSR_RESET[adc_seq_pkg::BIT_IE]; // R22 R1
			scan_mode_reg    <= adc_seq_pkg::CSR_RESET[adc_seq_pkg::BIT_SCAN]; // R4
			speed_select_reg <= adc_seq_pkg::CSR_RESET[adc_seq_pkg::BIT_SPEED]; // R5
			channel_sel_reg  <= adc_seq_pkg::CSR_RESET[2:0];
			trigger_enable_reg <= adc_seq_pkg::TRIG_RESET[adc_seq_pkg::BIT_TRIG_EN]; // R7
		end else begin
			if (wr_csr) begin
				end_interrupt_enable_reg <= w_byte_reg[adc_seq_pkg::BIT_IE]; // R1
				scan_mode_reg    <= w_byte_reg[adc_seq_pkg::BIT_SCAN]; // R4
				speed_select_reg <= w_byte_reg[adc_seq_pkg::BIT_SPEED]; // R5
				channel_sel_reg  <= w_byte_reg[2:0]; // R6 R19
			end
			if (wr_trig) begin
				trigger_enable_reg <= w_byte_reg[adc_seq_pkg::BIT_TRIG_EN]; // R9
			end
		end
	end

	// Run bit: hardware clear at single end, trigger set, software write last
	always_ff @(posedge aclk) begin
		if (init) begin
			run_bit_reg <= adc_seq_pkg::CSR_RESET[adc_seq_pkg::BIT_RUN]; // R22
		end else if (wr_csr) begin
			run_bit_reg <= w_byte_reg[adc_seq_pkg::BIT_RUN]; // R2 R11
		end else if (trig_fall && trigger_enable_reg) begin
			run_bit_reg <= 1'b1; // R8 R11
		end else if (conv_done && !scan_mode_reg) begin
			run_bit_reg <= 1'b0; // R2 R12
		end
	end
	// Flag arms on a read that sees it set; a later zero write clears it
	always_ff @(posedge aclk) begin
		if (init) begin
			flag_read_armed_reg <= 1'b0;
		end else if (rd_take && araddr == adc_seq_pkg::ADDR_CSR && end_flag_reg) begin
			flag_read_armed_reg <= 1'b1; // R14
		end else if (wr_csr) begin
			flag_read_armed_reg <= 1'b0;
		end
	end
	// End flag; a completion in the clearing cycle keeps the flag set
	always_ff @(posedge aclk) begin
		if (init) begin
			end_flag_reg <= adc_seq_pkg::CSR_RESET[adc_seq_pkg::BIT_END_FLAG];
		end else if (conv_done && last_channel) begin
			end_flag_reg <= 1'b1; // R12 R20
		end else if (wr_csr && flag_read_armed_reg && !w_byte_reg[adc_seq_pkg::BIT_END_FLAG]) begin
			end_flag_reg <= 1'b0; // R14
		end
	end

	// Request is a level that follows the flag while enabled
	assign conversion_end_request = end_flag_reg && end_interrupt_enable_reg; // R13 R1

	// ==========================================================
	// Conversion sequencer
	assign step_len   = speed_select_reg ? adc_seq_pkg::STEP_FAST : adc_seq_pkg::STEP_SLOW; // R5
	assign sample_len = speed_select_reg ? adc_seq_pkg::SAMPLE_FAST : adc_seq_pkg::SAMPLE_SLOW;
	assign conv_done  = (state_reg == adc_seq_pkg::ST_STEP) && (timer_reg == 8'h00) &&
	                    (bit_idx_reg == 3'h0);
	assign last_channel = !scan_mode_reg || (channel_reg[1:0] == channel_sel_reg[1:0]); // R20
	assign analog_channel = channel_reg;
	assign dac_code       = sar_reg;
	assign sampling       = (state_reg == adc_seq_pkg::ST_SAMPLE);

	// A run-bit clear idles on the write's own edge, so the sequencer never
	// runs a cycle without the run bit and restarts begin afresh
	always_ff @(posedge aclk) begin
		if (init || !run_bit_reg || (wr_csr && !w_byte_reg[adc_seq_pkg::BIT_RUN])) begin
			state_reg   <= adc_seq_pkg::ST_IDLE; // R2 R23
			timer_reg   <= 8'h00;
			bit_idx_reg <= 3'h0;
			sar_reg     <= '0;
			channel_reg <= 3'h0;
		end else begin
			unique case (state_reg)
				adc_seq_pkg::ST_IDLE: begin
					state_reg   <= adc_seq_pkg::ST_SAMPLE; // R11
					timer_reg   <= 8'(sample_len - 8'h01); // R24
					channel_reg <= scan_mode_reg ? {channel_sel_reg[2], 2'h0} // R15
					                             : channel_sel_reg; // R6
				end
				adc_seq_pkg::ST_SAMPLE: begin
					if (timer_reg == 8'h00) begin
						state_reg   <= adc_seq_pkg::ST_STEP;
						timer_reg   <= 8'(step_len - 8'h01);
						bit_idx_reg <= 3'(DATA_W - 1);
						sar_reg     <= DATA_W'(1) << (DATA_W - 1); // R10
					end else begin
						timer_reg <= 8'(timer_reg - 8'h01);
					end
				end
				adc_seq_pkg::ST_STEP: begin
					if (timer_reg != 8'h00) begin
						timer_reg <= 8'(timer_reg - 8'h01);
					end else begin
						// Keep the trial bit only if the input is above it
						if (!comparator_high) begin
							sar_reg[bit_idx_reg] <= 1'b0; // R10
						end
						if (bit_idx_reg != 3'h0) begin
							sar_reg[bit_idx_reg - 3'h1] <= 1'b1;
							bit_idx_reg <= 3'(bit_idx_reg - 3'h1);
							timer_reg   <= 8'(step_len - 8'h01);
						end else if (scan_mode_reg) begin
							state_reg <= adc_seq_pkg::ST_SAMPLE; // R3 R16
							timer_reg <= 8'(sample_len - 8'h01);
							channel_reg <= last_channel ? {channel_sel_reg[2], 2'h0}
							                            : 3'(channel_reg + 3'h1);
						end else begin
							state_reg <= adc_seq_pkg::ST_IDLE; // R12
						end
					end
				end
			endcase
		end
	end

	// Result registers, one per channel pair
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_result
			always_ff @(posedge aclk) begin
				if (init) begin
					result_reg[gi] <= adc_seq_pkg::RESULT_RESET; // R22
				end else if (conv_done && channel_reg[1:0] == 2'(gi)) begin
					result_reg[gi] <= comparator_high ? sar_reg
					                  : (sar_reg & ~DATA_W'(1)); // R17 R21
				end
			end
		end
	endgenerate

	// ==========================================================
	// Checks
	logic [8:0] conv_cycles_reg;
	always_ff @(posedge aclk) begin
		if (!aresetn || state_reg == adc_seq_pkg::ST_IDLE || conv_done) begin
			conv_cycles_reg <= 9'h000;
		end else begin
			conv_cycles_reg <= 9'(conv_cycles_reg + 9'h001);
		end
	end

	a_request_gated: assert property (@(posedge aclk) disable iff (!aresetn) // R1
		!end_interrupt_enable_reg |-> !conversion_end_request)
		else $error("request raised while disabled");
	a_request_follows_flag: assert property (@(posedge aclk) disable iff (!aresetn) // R13
		$rose(end_flag_reg) && end_interrupt_enable_reg |-> conversion_end_request)
		else $error("request missing after flag set");
	a_run_held_busy: assert property (@(posedge aclk) disable iff (!aresetn) // R12
		state_reg != adc_seq_pkg::ST_IDLE |-> run_bit_reg)
		else $error("busy without run bit");
	a_single_end_halts: assert property (@(posedge aclk) disable iff (!aresetn) // R2
		conv_done && !scan_mode_reg && !wr_csr && !standby && !trig_fall
		|=> !run_bit_reg && end_flag_reg ##1 state_reg == adc_seq_pkg::ST_IDLE)
		else $error("single conversion did not halt");
	a_conv_length: assert property (@(posedge aclk) disable iff (!aresetn) // R5
		conv_done && !$past(standby) |-> 32'(conv_cycles_reg) + 32'd1 ==
		(speed_select_reg ? adc_seq_pkg::STATES_FAST : adc_seq_pkg::STATES_SLOW))
		else $error("conversion length wrong");
	a_scan_first_channel: assert property (@(posedge aclk) disable iff (!aresetn) // R15
		state_reg == adc_seq_pkg::ST_IDLE && run_bit_reg && scan_mode_reg && !standby
		|=> analog_channel == {channel_sel_reg[2], 2'h0})
		else $error("scan did not start at group head");
	a_scan_next_now: assert property (@(posedge aclk) disable iff (!aresetn) // R16
		conv_done && scan_mode_reg && run_bit_reg && !standby && !wr_csr
		|=> state_reg == adc_seq_pkg::ST_SAMPLE)
		else $error("scan did not continue at once");
	a_flag_clear_read: assert property (@(posedge aclk) disable iff (!aresetn) // R14
		$fell(end_flag_reg) && !$past(standby) |-> $past(flag_read_armed_reg))
		else $error("flag cleared without prior read");
	a_trig_reserved: assert property (@(posedge aclk) disable iff (!aresetn) // R9
		rd_take && araddr == adc_seq_pkg::ADDR_TRIG |=> rdata[6:0] == adc_seq_pkg::TRIG_RESERVED)
		else $error("reserved trigger bits not one");
	a_trigger_starts: assert property (@(posedge aclk) disable iff (!aresetn) // R8
		trig_fall && trigger_enable_reg && !wr_csr && !standby
		|=> run_bit_reg ##1 state_reg == adc_seq_pkg::ST_SAMPLE)
		else $error("trigger did not start conversion");
	a_standby_init: assert property (@(posedge aclk) disable iff (!aresetn) // R7
		standby |=> trigger_enable_reg == 1'b0 && csr_value == adc_seq_pkg::CSR_RESET)
		else $error("standby did not initialise registers");

endmodule // adc_sequence_control

// ===== analog_front_model.sv
`timescale 1ns/1ps
// ==========================================================
// Analog front end seen by the converter
module analog_front_model #(
	parameter logic [63:0] LEVELS = 64'h0
) (
	// Converter side
	input  wire logic [2:0] analog_channel,
	input  wire logic [7:0] dac_code,
	input  wire logic       sampling,
	// Comparator
	output logic            comparator_high
);
	// Inputs sit half a step above their level, so a trial code never ties.
	// While sampling the output means nothing, so it churns with the code.
	always_comb begin
		if (sampling) begin
			comparator_high = ~dac_code[0];
		end else begin
			comparator_high = (dac_code <= LEVELS[analog_channel * 8 +: 8]);
		end
	end
endmodule // analog_front_model

// ===== adc_sequence_control_tb_top.sv
`timescale 1ns/1ps
// ==========================================================
// Bench for the converter sequencer
module adc_sequence_control_tb_top;
	localparam logic [63:0] LEVELS = 64'hFF7E81C33CA55A00; // Inputs 7 down to 0
	localparam int          LIMIT  = 20000;
	logic        aclk = 1'b0;
	logic        aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic        standby, external_trigger_n, comparator_high, sampling;
	logic        awready, wready, bvalid, arready, rvalid, conversion_end_request;
	logic [17:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp;
	logic [2:0]  analog_channel;
	logic [7:0]  dac_code;
	int          err_total = 0;
	int          tests_run = 0;
	int          cyc = 0;

	adc_sequence_control i_adc_sequence_control (.aclk, .aresetn, .awaddr, .awvalid, .awready,
		.wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
		.arready, .rdata, .rresp, .rvalid, .rready, .standby, .external_trigger_n,
		.comparator_high, .analog_channel, .dac_code, .sampling, .conversion_end_request);
	analog_front_model #(.LEVELS(LEVELS)) i_analog_front_model (.analog_channel, .dac_code,
		.sampling, .comparator_high);

	// ==========================================================
	// Clock and hang guard
	always #10 aclk = ~aclk;
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == LIMIT) begin
			err_total = err_total + 1;
			end_sim();
		end
	end

	// ==========================================================
	// Shared helpers
	function automatic logic [7:0] lev(input int k);
		return LEVELS[k * 8 +: 8];
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run = tests_run + 1;
		if (got !== exp) begin
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
			err_total = err_total + 1;
		end
	endtask
	// Address and data go out together; each drops once taken
	task automatic wr(input logic [17:0] a, input logic [7:0] d, input logic [1:0] er);
		logic aw_ok;
		logic w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge aclk);
			if (awvalid && awready === 1'b1) begin
				aw_ok = 1'b1;
				awvalid <= 1'b0;
			end
			if (wvalid && wready === 1'b1) begin
				w_ok = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (bvalid !== 1'b1);
		chk(32'(bresp), 32'(er));
	endtask
	task automatic rd(input logic [17:0] a, output logic [7:0] d, output logic [1:0] r);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		d = rdata[7:0];
		r = rresp;
	endtask
	task automatic rchk(input logic [17:0] a, input logic [7:0] e);
		logic [7:0] d;
		logic [1:0] r;
		rd(a, d, r);
		chk(32'(d), 32'(e));
		chk(32'(r), 32'(adc_seq_pkg::RESP_OKAY));
	endtask
	task automatic wait_samp(output int n);
		n = 0;
		while (sampling !== 1'b1 && n < 400) begin
			@(posedge aclk);
			n++;
		end
	endtask
	task automatic wait_req(output int n);
		n = 0;
		while (conversion_end_request !== 1'b1 && n < 400) begin
			@(posedge aclk);
			n++;
		end
	endtask
	// Rise to rise of the sample phase
	task automatic wait_rise(output int n);
		n = 0;
		while (sampling === 1'b1 && n < 400) begin
			@(posedge aclk);
			n++;
		end
		while (sampling !== 1'b1 && n < 800) begin
			@(posedge aclk);
			n++;
		end
	endtask
	// Reading first lets the config write also clear a pending end flag
	task automatic start(input logic [7:0] csr);
		logic [7:0] d;
		logic [1:0] r;
		rd(adc_seq_pkg::ADDR_CSR, d, r);
		wr(adc_seq_pkg::ADDR_CSR, csr, adc_seq_pkg::RESP_OKAY);
	endtask
	task automatic conv(input logic [7:0] csr, input logic [2:0] ch, output int n);
		start(csr);
		wait_samp(n);
		chk(32'(analog_channel), 32'(ch));
		wait_req(n);
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_regs();
		logic [7:0] d;
		logic [1:0] r;
		rchk(adc_seq_pkg::ADDR_CSR, 8'h00);
		rchk(adc_seq_pkg::ADDR_TRIG, 8'h7F);
		rchk(adc_seq_pkg::ADDR_RESULT2, 8'h00);
		wr(adc_seq_pkg::ADDR_TRIG, 8'h00, adc_seq_pkg::RESP_OKAY);
		rchk(adc_seq_pkg::ADDR_TRIG, 8'h7F);
		wr(adc_seq_pkg::ADDR_TRIG, 8'h80, adc_seq_pkg::RESP_OKAY);
		rchk(adc_seq_pkg::ADDR_TRIG, 8'hFF);
		wr(adc_seq_pkg::ADDR_RESULT0, 8'h55, adc_seq_pkg::RESP_SLVERR);
		rchk(adc_seq_pkg::ADDR_RESULT0, 8'h00);
		rd(18'h00010, d, r);
		chk(32'(r), 32'(adc_seq_pkg::RESP_SLVERR));
		wstrb <= 4'hE;
		wr(adc_seq_pkg::ADDR_TRIG, 8'h00, adc_seq_pkg::RESP_OKAY);
		wstrb <= 4'hF;
		rchk(adc_seq_pkg::ADDR_TRIG, 8'hFF);
		wr(adc_seq_pkg::ADDR_TRIG, 8'h00, adc_seq_pkg::RESP_OKAY);
	endtask
	task automatic t_single();
		int n;
		conv(8'h61, 3'h1, n);
		chk(32'(n > adc_seq_pkg::STATES_SLOW - 4 && n <= adc_seq_pkg::STATES_SLOW), 1);
		rchk(adc_seq_pkg::ADDR_CSR, 8'hC1);
		rchk(adc_seq_pkg::ADDR_RESULT1, lev(1));
		chk(32'(conversion_end_request), 1);
		wr(adc_seq_pkg::ADDR_CSR, 8'hC1, adc_seq_pkg::RESP_OKAY);
		chk(32'(conversion_end_request), 1);
		wr(adc_seq_pkg::ADDR_CSR, 8'h41, adc_seq_pkg::RESP_OKAY);
		chk(32'(conversion_end_request), 1);
		rchk(adc_seq_pkg::ADDR_CSR, 8'hC1);
		wr(adc_seq_pkg::ADDR_CSR, 8'h41, adc_seq_pkg::RESP_OKAY);
		rchk(adc_seq_pkg::ADDR_CSR, 8'h41);
		chk(32'(conversion_end_request), 0);
	endtask
	task automatic t_fast();
		int n;
		conv(8'h6F, 3'h7, n);
		chk(32'(n > adc_seq_pkg::STATES_FAST - 4 && n <= adc_seq_pkg::STATES_FAST), 1);
		rchk(adc_seq_pkg::ADDR_RESULT3, lev(7));
		rchk(adc_seq_pkg::ADDR_CSR, 8'hCF);
	endtask
	task automatic t_scan();
		int n;
		int k;
		start(8'h32);
		for (k = 0; k < 4; k++) begin
			wait_rise(n);
			chk(32'(analog_channel), 32'(k % 3));
			if (k > 0) chk(32'(n <= adc_seq_pkg::STATES_SLOW + 1), 1);
			if (k == 1) rchk(adc_seq_pkg::ADDR_CSR, 8'h32);
		end
		rchk(adc_seq_pkg::ADDR_CSR, 8'hB2);
		chk(32'(conversion_end_request), 0);
		for (k = 0; k < 3; k++) rchk(adc_seq_pkg::ADDR_RESULT0 + 18'(8 * k), lev(k));
		wait_rise(n);
		wr(adc_seq_pkg::ADDR_CSR, 8'h12, adc_seq_pkg::RESP_OKAY);
		rchk(adc_seq_pkg::ADDR_CSR, 8'h12);
		wr(adc_seq_pkg::ADDR_CSR, 8'h36, adc_seq_pkg::RESP_OKAY);
		wait_rise(n);
		chk(32'(analog_channel), 4);
		wr(adc_seq_pkg::ADDR_CSR, 8'h16, adc_seq_pkg::RESP_OKAY);
	endtask
	task automatic t_trig();
		int n;
		wr(adc_seq_pkg::ADDR_TRIG, 8'h80, adc_seq_pkg::RESP_OKAY);
		start(8'h43);
		external_trigger_n <= 1'b0;
		repeat (4) @(posedge aclk);
		external_trigger_n <= 1'b1;
		wait_samp(n);
		chk(32'(n < 20), 1);
		chk(32'(analog_channel), 3);
		wait_req(n);
		rchk(adc_seq_pkg::ADDR_RESULT3, lev(3));
		wr(adc_seq_pkg::ADDR_TRIG, 8'h00, adc_seq_pkg::RESP_OKAY);
		start(8'h43);
		external_trigger_n <= 1'b0;
		repeat (4) @(posedge aclk);
		external_trigger_n <= 1'b1;
		repeat (30) @(posedge aclk);
		rchk(adc_seq_pkg::ADDR_CSR, 8'h43);
	endtask
	task automatic t_stby();
		int n;
		conv(8'h68, 3'h0, n);
		chk(32'(conversion_end_request), 1);
		wr(adc_seq_pkg::ADDR_TRIG, 8'h80, adc_seq_pkg::RESP_OKAY);
		standby <= 1'b1;
		repeat (2) @(posedge aclk);
		standby <= 1'b0;
		@(posedge aclk);
		chk(32'(conversion_end_request), 0);
		rchk(adc_seq_pkg::ADDR_CSR, 8'h00);
		rchk(adc_seq_pkg::ADDR_TRIG, 8'h7F);
		rchk(adc_seq_pkg::ADDR_RESULT3, 8'h00);
	endtask

	// ==========================================================
	// Verdict and main sequence
	task automatic end_sim();
		$display("Comparisons %0d, mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	initial begin
		aresetn = 1'b0;
		{awaddr, araddr, wdata} = '0;
		{awvalid, wvalid, arvalid, standby} = '0;
		wstrb = 4'hF;
		bready = 1'b1;
		rready = 1'b1;
		external_trigger_n = 1'b1;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_regs();
		t_single();
		t_fast();
		t_scan();
		t_trig();
		t_stby();
		end_sim();
	end
endmodule // adc_sequence_control_tb_top
